// File: src/ucr_top.v
// receive path and configuration registers of the serial port
//
// Functional notes
// [RULE_01] queue enable: 16 deep, else single
// [RULE_02] char size codes 5..8 bits, right-aligned
// [RULE_03] parity enable, even when set, odd otherwise
// [RULE_04] one divisor: ref / (16*(div+1))
// [RULE_05] infrared pulse lasts 3/16 bit
// [RULE_06] infrared low power control bit
// [RULE_07] one shared modem input polarity bit
// [RULE_08] transmit polarity inverts output line
// [RULE_09] receive polarity: low reads as one
// [RULE_10] infrared disable bit selects wired mode
// [RULE_11] unselected receive pin is ignored
// [RULE_12] falling edge starts; tick 8 confirms start
// [RULE_13] data sampled mid-bit, count by size
// [RULE_14] first stop checked; framing error stored
// [RULE_15] queue level flag at eight entries
// [RULE_16] single mode: level flag while entry held
// [RULE_17] raw flags, masked by enable bits
// [RULE_18] full queue: keep entries, flag overrun
// [RULE_19] idle timeout after 32 cycles, read clears
// [RULE_20] disable stops at frame boundary, gates baud
// [RULE_21] parity mismatch flag stored with character
// [RULE_22] long space stores one break character
// [RULE_23] frame: start, data lsb first, parity, stop
// [RULE_24] two stop select for transmitter
// [RULE_25] combined interrupt ORs masked flags
// [RULE_26] baud counter reloads, sixteen ticks per bit
// [RULE_27] queue full/empty status; data read pops
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ucr_regs.vh"
module ucr_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire wired_rx_pin,
    input wire ir_rx_pin,
    output reg combined_irq,
    output reg ir_low_power,
    output reg modem_line_polarity,
    output reg transmit_polarity,
    output reg two_stop_select
);
    // reference tick: 7.3728 MHz from pclk by phase accumulator
    localparam [31:0] REF_INC = `UCR_REF_INC;
    localparam S_MARK = 6'b000001;
    localparam S_START = 6'b000010;
    localparam S_DATA = 6'b000100;
    localparam S_PAR = 6'b001000;
    localparam S_STOP = 6'b010000;
    localparam S_BRK = 6'b100000;

    function [3:0] nbits;
        input [1:0] code;
        begin
            nbits = {2'b00, code} + 4'h5;
        end
    endfunction

    reg [5:0] frame_queue_setup_q;
    reg [5:0] con_q;
    reg [15:0] rate_divider_reg_q;
    reg [1:0] mask_q;
    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    wire acc = psel & penable & ~pready_q;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire data_rd = rd & (paddr == `UCR_OFF_DATA);
    wire q_en = frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_FEN];
    wire port_en = con_q[`UCR_CON_EN];

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg [1:0] wsync_q;
    reg [1:0] isync_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wsync_q <= 2'b11;
            isync_q <= 2'b00;
        end else begin
            wsync_q <= {wsync_q[0], wired_rx_pin};
            isync_q <= {isync_q[0], ir_rx_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // baud tick generation
    reg [31:0] ph_q;
    reg ref_tick_q;
    reg [15:0] bcnt_q;
    reg tick_q;
    reg [5:0] st_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 32'h00000000;
            ref_tick_q <= 1'b0;
            bcnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            {ref_tick_q, ph_q} <= {1'b0, ph_q} + {1'b0, REF_INC};
            tick_q <= 1'b0;
            // [RULE_20] gated when disabled, after the frame in flight
            if (ref_tick_q && (port_en || st_q != S_MARK)) begin
                // [RULE_26] reload divisor, one tick per expiry
                if (bcnt_q == 16'h0000) begin
                    bcnt_q <= rate_divider_reg_q;
                    // [RULE_04] sixteen ticks per bit at div+1
                    tick_q <= 1'b1;
                end else begin
                    bcnt_q <= bcnt_q - 16'h0001;
                end
            end
        end
    end

    reg [3:0] ir_hold_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ir_hold_q <= 4'h0;
        else if (isync_q[1])
            ir_hold_q <= 4'hf;
        else if (tick_q && ir_hold_q != 4'h0)
            ir_hold_q <= ir_hold_q - 4'h1;
    end
    // [RULE_10] [RULE_11] one pin; ir pulse held so mid-bit sees it
    wire raw_line = con_q[`UCR_CON_IR_OFF] ? wsync_q[1] :
        ~(isync_q[1] | (|ir_hold_q));
    // [RULE_09] receive polarity
    wire rx_bit = raw_line ^ con_q[`UCR_CON_RXP];

    ////////////////////////////////////////////////////////////////////
    // receive shifter
    reg [3:0] sub_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg par_q;
    reg pe_q;
    reg [4:0] zc_q;
    reg prev_q;
    reg push_q;
    reg [10:0] push_w_q;
    wire [3:0] nb = nbits(frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_CHAR_SIZE_LO +: 2]);
    wire mid = tick_q && (sub_q == 4'h7);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_MARK;
            sub_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            par_q <= 1'b0;
            pe_q <= 1'b0;
            zc_q <= 5'h00;
            prev_q <= 1'b1;
            push_q <= 1'b0;
            push_w_q <= 11'h000;
        end else begin
            push_q <= 1'b0;
            prev_q <= rx_bit;
            if (tick_q)
                sub_q <= sub_q + 4'h1;
            case (st_q)
                S_MARK: begin
                    // [RULE_12] falling edge while marking
                    if (port_en && prev_q && !rx_bit) begin
                        st_q <= S_START;
                        sub_q <= 4'h0;
                    end
                end
                S_START: begin
                    // [RULE_12] tick 8 confirms or rejects
                    if (mid) begin
                        if (rx_bit) begin
                            st_q <= S_MARK;
                        end else begin
                            st_q <= S_DATA;
                            bit_q <= 4'h0;
                            sh_q <= 8'h00;
                            par_q <= 1'b0;
                            zc_q <= 5'h01;
                            sub_q <= 4'h8;
                        end
                    end
                end
                S_DATA: begin
                    // [RULE_13] [RULE_23] mid-bit sample, lsb first
                    if (mid) begin
                        // [RULE_02] right-aligned by shift position
                        sh_q[bit_q[2:0]] <= rx_bit;
                        par_q <= par_q ^ rx_bit;
                        zc_q <= rx_bit ? 5'h00 : zc_q + {4'h0, |zc_q};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q + 4'h1 == nb)
                            st_q <= frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_PEN] ? S_PAR : S_STOP;
                    end
                end
                S_PAR: begin
                    if (mid) begin
                        // [RULE_03] [RULE_21] even select gives even
                        pe_q <= (par_q ^ rx_bit) ==
                            frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_EPS];
                        zc_q <= rx_bit ? 5'h00 : zc_q + {4'h0, |zc_q};
                        st_q <= S_STOP;
                    end
                end
                S_STOP: begin
                    // [RULE_14] only the first stop is checked
                    if (mid) begin
                        push_q <= 1'b1;
                        // [RULE_22] all-space frame becomes a break
                        if (!rx_bit && zc_q != 5'h00) begin
                            push_w_q <= 11'h400;
                            st_q <= S_BRK;
                        end else begin
                            push_w_q <= {1'b0, !rx_bit,
                                frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_PEN] & pe_q, sh_q};
                            st_q <= S_MARK;
                        end
                        pe_q <= 1'b0;
                    end
                end
                S_BRK: begin
                    // [RULE_22] wait for marking before new start
                    if (rx_bit)
                        st_q <= S_MARK;
                end
                default: st_q <= S_MARK;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive queue: word = be, fe, pe, data; oe is added on read
    reg [10:0] mem [0:15];
    reg [3:0] wp_q;
    reg [3:0] rp_q;
    reg [4:0] cnt_q;
    reg oe_q;
    reg [5:0] idle_q;
    reg rti_q;
    // [RULE_01] depth is 16 or one
    wire [4:0] cap = q_en ? 5'd16 : 5'd1;
    wire full = (cnt_q == cap);
    wire pop = data_rd && (cnt_q != 5'd0);
    // [RULE_18] no store into a full queue or pending overrun
    wire store = push_q && !full && !oe_q;
    always @(posedge pclk) begin
        if (store)
            mem[wp_q] <= push_w_q[10:0];
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            cnt_q <= 5'd0;
            oe_q <= 1'b0;
            idle_q <= 6'd0;
            rti_q <= 1'b0;
        end else begin
            if (store)
                wp_q <= wp_q + 4'h1;
            if (pop)
                rp_q <= rp_q + 4'h1;
            if (store && !pop)
                cnt_q <= cnt_q + 5'd1;
            else if (pop && !store)
                cnt_q <= cnt_q - 5'd1;
            // [RULE_18] overrun sets on full; set wins over read
            if (push_q && (full || oe_q))
                oe_q <= 1'b1;
            else if (pop && cnt_q == 5'd1)
                oe_q <= 1'b0;
            // [RULE_19] idle counter runs while data waits
            if (cnt_q == 5'd0 || push_q)
                idle_q <= 6'd0;
            else if (idle_q != `UCR_TIMEOUT_CYC)
                idle_q <= idle_q + 6'd1;
            if (cnt_q != 5'd0 && idle_q == `UCR_TIMEOUT_CYC - 6'd1)
                rti_q <= 1'b1;
            else if (data_rd)
                rti_q <= 1'b0;
        end
    end
    // overrun shows on the newest stored character when read last
    wire [10:0] head = mem[rp_q];
    wire last = (cnt_q == 5'd1);
    // [RULE_15] [RULE_16] level flag by mode
    wire ri = q_en ? (cnt_q >= `UCR_HALF) : (cnt_q != 5'd0);
    // [RULE_17] raw flags and masked view
    wire [1:0] raw = {rti_q, ri};
    wire [1:0] masked_irq_flags = raw & mask_q;

    ////////////////////////////////////////////////////////////////////
    // apb slave, one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_queue_setup_q <= `UCR_FRAME_QUEUE_SETUP_RST;
            con_q <= `UCR_CON_RST;
            rate_divider_reg_q <= `UCR_RATE_DIVIDER_REG_RST;
            mask_q <= 2'b00;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            combined_irq <= 1'b0;
            ir_low_power <= 1'b0;
            modem_line_polarity <= 1'b0;
            transmit_polarity <= 1'b0;
            two_stop_select <= 1'b0;
        end else begin
            pready_q <= acc;
            pslverr_q <= 1'b0;
            // [RULE_25] or of masked flags
            combined_irq <= |masked_irq_flags;
            // [RULE_06] low power infrared
            ir_low_power <= con_q[`UCR_CON_IR_LOW_POWER];
            // [RULE_07] one polarity for all modem inputs
            modem_line_polarity <= con_q[`UCR_CON_MXP];
            // [RULE_08] [RULE_05] feed the transmit encoder
            transmit_polarity <= con_q[`UCR_CON_TXP];
            // [RULE_24] stop count for transmitter
            two_stop_select <= frame_queue_setup_q[`UCR_FRAME_QUEUE_SETUP_TWO_STOP_SELECT];
            if (wr) begin
                case (paddr)
                    `UCR_OFF_FRAME_QUEUE_SETUP: frame_queue_setup_q <= pwdata[5:0];
                    `UCR_OFF_RATE_DIVIDER_REG: rate_divider_reg_q <= pwdata[15:0];
                    `UCR_OFF_CON: con_q <= pwdata[5:0];
                    `UCR_OFF_MASK: mask_q <= pwdata[1:0];
                    `UCR_OFF_DATA: ;
                    default: pslverr_q <= 1'b1;
                endcase
            end
            if (rd) begin
                case (paddr)
                    // [RULE_27] [RULE_20] data readable when disabled
                    `UCR_OFF_DATA: prdata_q <= (cnt_q == 5'd0) ?
                        32'h00000000 :
                        {20'h00000, oe_q & last, head[10:0]};
                    `UCR_OFF_FRAME_QUEUE_SETUP: prdata_q <= {26'h0, frame_queue_setup_q};
                    `UCR_OFF_RATE_DIVIDER_REG: prdata_q <= {16'h0, rate_divider_reg_q};
                    `UCR_OFF_CON: prdata_q <= {26'h0, con_q};
                    // [RULE_27] full and empty status
                    `UCR_OFF_STATUS: prdata_q <= {30'h0, full,
                        cnt_q == 5'd0};
                    `UCR_OFF_RAW: prdata_q <= {30'h0, raw};
                    `UCR_OFF_MASK: prdata_q <= {30'h0, mask_q};
                    `UCR_OFF_ISR: prdata_q <= {30'h0, masked_irq_flags};
                    default: begin
                        prdata_q <= 32'h00000000;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: src/ucr_regs.vh
// register offsets, field positions and timing counts for the serial port
`ifndef UCR_REGS_VH
`define UCR_REGS_VH
`define UCR_OFF_DATA 12'h000
`define UCR_OFF_FRAME_QUEUE_SETUP 12'h004
`define UCR_OFF_RATE_DIVIDER_REG 12'h008
`define UCR_OFF_CON 12'h00c
`define UCR_OFF_STATUS 12'h010
`define UCR_OFF_RAW 12'h014
`define UCR_OFF_MASK 12'h018
`define UCR_OFF_ISR 12'h01c
`define UCR_FRAME_QUEUE_SETUP_TWO_STOP_SELECT 0
`define UCR_FRAME_QUEUE_SETUP_PEN 1
`define UCR_FRAME_QUEUE_SETUP_EPS 2
`define UCR_FRAME_QUEUE_SETUP_CHAR_SIZE_LO 3
`define UCR_FRAME_QUEUE_SETUP_FEN 5
`define UCR_CON_EN 0
`define UCR_CON_IR_OFF 1
`define UCR_CON_IR_LOW_POWER 2
`define UCR_CON_MXP 3
`define UCR_CON_TXP 4
`define UCR_CON_RXP 5
`define UCR_FRAME_QUEUE_SETUP_RST 6'h00
`define UCR_CON_RST 6'h02
`define UCR_RATE_DIVIDER_REG_RST 16'h0000
`define UCR_IRQ_RI 0
`define UCR_IRQ_RTI 1
`define UCR_QDEPTH 16
`define UCR_HALF 5'd8
`define UCR_TIMEOUT_CYC 6'd32
`define UCR_REF_HZ 7372800
`define UCR_PCLK_HZ 100000000
`define UCR_REF_INC 32'd316659349
`endif

// File: testbench/ucr_chk.sv
// assertions on the serial port bus and setup outputs
`timescale 1ns/100ps
`default_nettype none
module ucr_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic combined_irq,
    input wire logic ir_low_power,
    input wire logic modem_line_polarity,
    input wire logic transmit_polarity,
    input wire logic two_stop_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // a write completing at this edge
    sequence s_wr(a);
        pready && pwrite && psel && paddr == a;
    endsequence
    a_one_wait: assert property (s_wait |=> pready)
        else $error("no answer after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_rdy_cause: assert property (pready |-> $past(penable))
        else $error("ready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_cfg_copy: assert property (s_wr(12'h00c) |=>
        {transmit_polarity, modem_line_polarity, ir_low_power}
            == $past(pwdata[4:2]))
        else $error("setup outputs wrong");
    a_stop_copy: assert property (s_wr(12'h004) |=>
        two_stop_select == $past(pwdata[0]))
        else $error("stop select wrong");
    a_cfg_hold: assert property (!(pready && pwrite) |=>
        $stable({ir_low_power, modem_line_polarity, transmit_polarity,
            two_stop_select}))
        else $error("setup output moved");
    a_irq_off: assert property (s_wr(12'h018) ##0 pwdata[1:0] == 0
        |-> ##2 !combined_irq)
        else $error("masked interrupt seen");
endmodule
bind ucr_top ucr_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .combined_irq(combined_irq),
    .ir_low_power(ir_low_power),
    .modem_line_polarity(modem_line_polarity),
    .transmit_polarity(transmit_polarity),
    .two_stop_select(two_stop_select)
);
`default_nettype wire

// File: testbench/ucr_line_model.sv
// far-end transmitter driving the wired and infrared inputs
`timescale 1ns/100ps
`default_nettype none
module ucr_line_model #(
    parameter int BITC = 217
) (
    input wire logic clk,
    input wire logic inv,
    output wire logic line,
    output var logic ir_line
);
    localparam int PULSE = BITC * 3 / 16;
    logic raw = 1'b1;
    initial ir_line = 1'b0;
    assign line = raw ^ inv;
    ////////////////////////////////////////////////////////////
    // start, lsb first
    task automatic send(input logic [11:0] b, input int n, input logic ir);
        for (int i = 0; i < n; i++) begin
            if (ir) begin
                ir_line <= !b[i];
                repeat (PULSE) @(posedge clk);
                ir_line <= 1'b0;
                repeat (BITC - PULSE) @(posedge clk);
            end else begin
                raw <= b[i];
                repeat (BITC) @(posedge clk);
            end
        end
        if (!raw)
            raw <= 1'b1;
    endtask
    task automatic glitch;
        raw <= 1'b0;
        repeat (BITC / 4) @(posedge clk);
        raw <= 1'b1;
        repeat (BITC) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: testbench/ucr_top_bench.sv
// self-checking bench for the serial port setup and receive path
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module ucr_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic inv = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, ex;
    logic pready, pslverr, irq, ir_lp, mod_pol, tx_pol, stop2;
    logic line, irl, err;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    ucr_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wired_rx_pin(line),
        .ir_rx_pin(irl), .combined_irq(irq), .ir_low_power(ir_lp),
        .modem_line_polarity(mod_pol), .transmit_polarity(tx_pol),
        .two_stop_select(stop2)
    );
    ucr_line_model #(.BITC(217)) far (
        .clk(pclk), .inv(inv), .line(line), .ir_line(irl)
    );
    ////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e,
            input logic [31:0] k = 32'h00000fff);
        bus(1'b0, a, 32'h0);
        `CHK(rd & k, e)
    endtask
    task automatic fr(input logic [7:0] d);
        far.send({3'b111, d, 1'b0}, 10, 1'b0);
    endtask
    task automatic end_sim;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // the run needs about 63000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h00c, 32'h02, 32'h3f);
        rc(12'h004, 32'h00, 32'h3f);
        rc(12'h008, 32'h0, 32'hffff);
        rc(12'h010, 32'h1, 32'h3);
        rc(12'h020, 32'h0, 32'hffffffff);
        `CHK(err, 1'b1)
        bus(1'b1, 12'h00c, 32'h1d);
        @(negedge pclk);
        `CHK({tx_pol, mod_pol, ir_lp}, 3'b111)
        bus(1'b1, 12'h00c, 32'h03);
        bus(1'b1, 12'h004, 32'h39);
        @(negedge pclk);
        `CHK({stop2, tx_pol, mod_pol, ir_lp}, 4'b1000)
        bus(1'b1, 12'h018, 32'h3);
        for (int i = 0; i < 17; i++) begin
            fr(8'h96 ^ 8'(i * 17));
            if (i == 6) rc(12'h014, 32'h0, 32'h1);
            if (i == 7) rc(12'h014, 32'h1, 32'h1);
            if (i == 7) `CHK(irq, 1'b1)
            if (i == 15) rc(12'h010, 32'h2, 32'h3);
        end
        rc(12'h01c, 32'h3, 32'h3);
        bus(1'b1, 12'h018, 32'h1);
        rc(12'h01c, 32'h1, 32'h3);
        bus(1'b1, 12'h018, 32'h0);
        rc(12'h01c, 32'h0, 32'h3);
        `CHK(irq, 1'b0)
        bus(1'b1, 12'h018, 32'h3);
        for (int i = 0; i < 16; i++) begin
            ex = {24'h0, 8'h96 ^ 8'(i * 17)};
            ex[11] = (i == 15);
            rc(12'h000, ex);
            if (i == 7) rc(12'h014, 32'h1, 32'h1);
            if (i == 8) rc(12'h014, 32'h0, 32'h1);
        end
        rc(12'h010, 32'h1, 32'h3);
        for (int c = 1; c < 3; c++) begin
            bus(1'b1, 12'h004, 32'(c << 3));
            far.send(12'hffe, c + 7, 1'b0);
            rc(12'h000, (32'h1 << (c + 5)) - 1);
        end
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, 12'h004, 32'h02 | 32'(e << 2));
            far.send(12'h0e6, 8, 1'b0);
            rc(12'h014, 32'h3, 32'h3);
            rc(12'h000, e ? 32'h013 : 32'h113);
            rc(12'h014, 32'h0, 32'h3);
        end
        bus(1'b1, 12'h004, 32'h18);
        far.send({3'b100, 8'h5a, 1'b0}, 10, 1'b0);
        rc(12'h000, 32'h25a);
        bus(1'b1, 12'h004, 32'h38);
        far.send(12'h000, 12, 1'b0);
        repeat (217) @(posedge pclk);
        rc(12'h000, 32'h400, 32'h4ff);
        rc(12'h010, 32'h1, 32'h1);
        fr(8'h3c);
        bus(1'b1, 12'h00c, 32'h02);
        fr(8'h11);
        rc(12'h000, 32'h03c);
        rc(12'h010, 32'h1, 32'h1);
        bus(1'b1, 12'h00c, 32'h03);
        far.glitch();
        far.send(12'heb4, 10, 1'b1);
        rc(12'h010, 32'h1, 32'h1);
        bus(1'b1, 12'h00c, 32'h01);
        far.send(12'heb4, 10, 1'b1);
        rc(12'h000, 32'h05a);
        fr(8'h77);
        rc(12'h010, 32'h1, 32'h1);
        bus(1'b1, 12'h00c, 32'h02);
        inv <= 1'b1;
        bus(1'b1, 12'h00c, 32'h23);
        fr(8'h5a);
        rc(12'h000, 32'h05a);
        end_sim();
    end
endmodule
`default_nettype wire
